// ===== hw/iprc_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the interrupt priority controller.
 * Assumes a 16-bit register port with word offsets.
 */
`ifndef IPRC_REGS_VH
`define IPRC_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define IPRC_OFS_SPI3U4 4'h0
`define IPRC_OFS_CAPCMP9 4'h1
`define IPRC_OFS_GFX 4'h2
`define IPRC_OFS_STATUS 4'h3
`define IPRC_OFS_SRCFLAG 4'h4
`define IPRC_OFS_SRCEN 4'h5
`define IPRC_OFS_CPUPRI 4'h6
`define IPRC_OFS_TRAPFLAG 4'h7

// ****************************************
// Field positions
// ****************************************
`define IPRC_SPF3_LSB 8
`define IPRC_U4TX_LSB 4
`define IPRC_U4RX_LSB 0
`define IPRC_CAP9_LSB 4
`define IPRC_CMP9_LSB 0
`define IPRC_GFX_LSB 0
`define IPRC_ST_PEND_BIT 15
`define IPRC_ST_VSEL_BIT 13
`define IPRC_ST_LVL_LSB 8
`define IPRC_ST_VEC_LSB 0

// ****************************************
// Reset values and masks
// ****************************************
`define IPRC_PRI_RESET 3'h4
`define IPRC_SPI3U4_MASK 16'h0777
`define IPRC_CAPCMP9_MASK 16'h0077
`define IPRC_GFX_MASK 16'h0007
`define IPRC_CPU_MASK_ALL 8'h0E
`define IPRC_PRI_MAX 3'h7

// ****************************************
// Timing
// ****************************************
`define IPRC_CLK_PERIOD_NS 5
`define IPRC_TIMED_INTERRUPT_DISABLE_TIME_NS 1000
`define IPRC_TIMED_INTERRUPT_DISABLE_CYCLES (`IPRC_TIMED_INTERRUPT_DISABLE_TIME_NS / `IPRC_CLK_PERIOD_NS)

`endif

// ===== hw/iprc_controller.v
/*
 * Interrupt priority controller: per-source priority fields, arbitration,
 * CPU priority masking, trap priority, timed disable and status register.
 * Assumes a CPU that acknowledges requests and pulses return and disable.
 */
`include "iprc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module iprc_controller #(
  parameter NSRC = 6,
  parameter NTRAP = 4,
  parameter [6:0] VEC_BASE = 7'h08,
  parameter TIMED_INTERRUPT_DISABLE_CYCLES = `IPRC_TIMED_INTERRUPT_DISABLE_CYCLES
) (
  // Clock and reset
  input wire CLK,
  input wire ARST_N,
  // Register port
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // Source and trap event pulses
  input wire [NSRC-1:0] SRC_EVENT,
  input wire [NTRAP-1:0] TRAP_EVENT,
  // CPU side
  input wire CPU_ACK,
  input wire CPU_RETURN,
  input wire CPU_TIMED_INTERRUPT_DISABLE,
  output reg IRQ,
  output reg [6:0] IRQ_VECTOR,
  output reg [3:0] IRQ_LEVEL
);

  // ****************************************
  // State
  // ****************************************
  reg [15:0] spi3u4_q;
  reg [15:0] capcmp9_q;
  reg [15:0] gfx_q;
  reg vsel_q;
  reg [NSRC-1:0] flag_q;
  reg [NSRC-1:0] en_q;
  reg [NTRAP-1:0] trap_q;
  reg [7:0] status_low_q;
  reg [3:0] saved_lvl_q;
  reg [6:0] ack_vec_q;
  reg [15:0] timed_interrupt_disable_cnt_q;
  reg [3:0] lvl_q;
  wire [3:0] cpu_lvl;
  wire [2:0] pri [0:NSRC-1];

  // Field extraction for the six sources
  // SPI3 fault and UART4 placement
  assign pri[0] = spi3u4_q[`IPRC_SPF3_LSB +: 3];
  assign pri[1] = spi3u4_q[`IPRC_U4TX_LSB +: 3];
  assign pri[2] = spi3u4_q[`IPRC_U4RX_LSB +: 3];
  assign pri[3] = capcmp9_q[`IPRC_CAP9_LSB +: 3];
  assign pri[4] = capcmp9_q[`IPRC_CMP9_LSB +: 3];
  assign pri[5] = gfx_q[`IPRC_GFX_LSB +: 3];
  // CPU level from status byte bits 7-5
  assign cpu_lvl = {1'b0, status_low_q[7:5]};

  // ****************************************
  // Per-source request qualification
  // ****************************************
  wire [NSRC-1:0] src_req;
  genvar g;

  // One qualifier per source: flagged, enabled, non-zero field
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : g_req
      assign src_req[g] = flag_q[g] && en_q[g] && (pri[g] != 3'h0);
    end
  endgenerate

  // ****************************************
  // Arbitration
  // ****************************************
  reg [3:0] best_lvl;
  reg [6:0] best_vec;
  reg best_ok;
  reg [3:0] eff;
  integer i;

  // Highest level wins, scan order gives lowest vector on ties
  always @*
  begin
    best_lvl = 4'h0;
    best_vec = 7'h00;
    best_ok = 1'b0;
    eff = 4'h0;
    for (i = NTRAP - 1; i >= 0; i = i - 1)
    begin
      if (trap_q[i] && (!best_ok || (4'h8 + i[3:0]) >= best_lvl))
      begin
        best_lvl = 4'h8 + i[3:0];
        best_vec = i[6:0];
        best_ok = 1'b1;
      end
    end
    if (!best_ok)
    begin
      for (i = NSRC - 1; i >= 0; i = i - 1)
      begin
        eff = {1'b0, pri[i]};
        if (src_req[i] && eff >= best_lvl)
        begin
          best_lvl = eff;
          best_vec = VEC_BASE + i[6:0];
          best_ok = 1'b1;
        end
      end
    end
  end

  // Request passes CPU level and timed disable
  wire timed_interrupt_disable_on = timed_interrupt_disable_cnt_q != 16'h0000;
  // Timed disable blocks levels 1-6 only
  wire timed_interrupt_disable_block = timed_interrupt_disable_on && best_lvl < 4'h7;
  wire take = best_ok && (best_lvl > cpu_lvl) && !timed_interrupt_disable_block;
  wire held = best_ok && !take;

  // ****************************************
  // Register write and event logic
  // ****************************************
  wire w_sp = WR && ADDR == `IPRC_OFS_SPI3U4;
  wire w_cc = WR && ADDR == `IPRC_OFS_CAPCMP9;
  wire w_gx = WR && ADDR == `IPRC_OFS_GFX;
  wire w_st = WR && ADDR == `IPRC_OFS_STATUS;
  wire w_fl = WR && ADDR == `IPRC_OFS_SRCFLAG;
  wire w_en = WR && ADDR == `IPRC_OFS_SRCEN;
  wire w_cp = WR && ADDR == `IPRC_OFS_CPUPRI;
  wire w_tr = WR && ADDR == `IPRC_OFS_TRAPFLAG;
  wire ack = CPU_ACK && IRQ;

  // Priority fields and vector select
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      spi3u4_q <= {5'h00, `IPRC_PRI_RESET, 1'b0, `IPRC_PRI_RESET, 1'b0, `IPRC_PRI_RESET};
      capcmp9_q <= {9'h000, `IPRC_PRI_RESET, 1'b0, `IPRC_PRI_RESET};
      gfx_q <= {13'h0000, `IPRC_PRI_RESET};
      vsel_q <= 1'b0;
    end
    else
    begin
      if (w_sp)
      begin
        spi3u4_q <= WDATA & `IPRC_SPI3U4_MASK;
      end
      if (w_cc)
      begin
        capcmp9_q <= WDATA & `IPRC_CAPCMP9_MASK;
      end
      if (w_gx)
      begin
        gfx_q <= WDATA & `IPRC_GFX_MASK;
      end
      // Vector select is the only writable status bit
      if (w_st)
      begin
        vsel_q <= WDATA[`IPRC_ST_VSEL_BIT];
      end
    end
  end

  // Source enables and source flags
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      flag_q <= {NSRC{1'b0}};
      en_q <= {NSRC{1'b0}};
    end
    else
    begin
      if (w_en)
      begin
        en_q <= WDATA[NSRC-1:0];
      end
      // Flags clear only by software; set wins
      flag_q <= (w_fl ? (flag_q & ~WDATA[NSRC-1:0]) : flag_q) | SRC_EVENT;
    end
  end

  // Trap flags
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      trap_q <= {NTRAP{1'b0}};
    end
    else
    begin
      // Trap flags stay until cleared; set wins
      trap_q <= (w_tr ? (trap_q & ~WDATA[NTRAP-1:0]) : trap_q) | TRAP_EVENT;
    end
  end

  // Timed disable counter, restarts on every disable pulse
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      timed_interrupt_disable_cnt_q <= 16'h0000;
    end
    else
    begin
      if (CPU_TIMED_INTERRUPT_DISABLE)
      begin
        timed_interrupt_disable_cnt_q <= TIMED_INTERRUPT_DISABLE_CYCLES[15:0];
      end
      else if (timed_interrupt_disable_on)
      begin
        timed_interrupt_disable_cnt_q <= timed_interrupt_disable_cnt_q - 16'h0001;
      end
    end
  end

  // CPU level, saved level and acknowledged vector
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      status_low_q <= 8'h00;
      saved_lvl_q <= 4'h0;
      ack_vec_q <= 7'h00;
      lvl_q <= 4'h0;
    end
    else
    begin
      // Acknowledge beats return, return beats software write
      if (ack)
      begin
        ack_vec_q <= IRQ_VECTOR;
        saved_lvl_q <= cpu_lvl;
        // Trap levels cap at 7 in the status byte
        status_low_q <= {IRQ_LEVEL > 4'h7 ? 3'h7 : IRQ_LEVEL[2:0], status_low_q[4:0]};
        lvl_q <= IRQ_LEVEL;
      end
      else if (CPU_RETURN)
      begin
        status_low_q <= {saved_lvl_q[2:0], status_low_q[4:0]};
        lvl_q <= saved_lvl_q;
      end
      else if (w_cp)
      begin
        // Software write, e.g. OR with 0Eh shifted into level
        status_low_q <= WDATA[7:0];
        lvl_q <= {1'b0, WDATA[7:5]};
      end
    end
  end

  // ****************************************
  // Outputs and read port
  // ****************************************
  reg [15:0] rd_d;
  reg [6:0] vec_shown;
  wire [15:0] status_word;
  wire [15:0] flag_word;
  wire [15:0] en_word;
  wire [15:0] trap_word;

  // Status word, unimplemented bits tied low
  // Bit 15 shows held request
  // Bits 11-8 show new CPU level
  // Bits 6-0 show the vector number
  assign status_word = {held, 1'b0, vsel_q, 1'b0, lvl_q, 1'b0, vec_shown};

  // Flag, enable and trap words padded with zeros
  assign flag_word = {{(16-NSRC){1'b0}}, flag_q};
  assign en_word = {{(16-NSRC){1'b0}}, en_q};
  assign trap_word = {{(16-NTRAP){1'b0}}, trap_q};

  // Read data mux
  always @*
  begin
    // Live pending vector when select is 1
    vec_shown = vsel_q ? best_vec : ack_vec_q;
    case (ADDR)
      // Priority registers
      `IPRC_OFS_SPI3U4: rd_d = spi3u4_q;
      `IPRC_OFS_CAPCMP9: rd_d = capcmp9_q;
      `IPRC_OFS_GFX: rd_d = gfx_q;
      // Controller status
      `IPRC_OFS_STATUS: rd_d = status_word;
      // Source flags and enables
      `IPRC_OFS_SRCFLAG: rd_d = flag_word;
      `IPRC_OFS_SRCEN: rd_d = en_word;
      // CPU status low byte
      `IPRC_OFS_CPUPRI: rd_d = {8'h00, status_low_q};
      // Trap flags
      `IPRC_OFS_TRAPFLAG: rd_d = trap_word;
      default: rd_d = 16'h0000;
    endcase
  end

  // Registered outputs
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RDATA <= 16'h0000;
      IRQ <= 1'b0;
      IRQ_VECTOR <= 7'h00;
      IRQ_LEVEL <= 4'h0;
    end
    else
    begin
      RDATA <= RD ? rd_d : 16'h0000;
      IRQ <= take && !ack;
      IRQ_VECTOR <= best_vec;
      IRQ_LEVEL <= best_lvl;
    end
  end

endmodule // iprc_controller

`default_nettype wire

// ===== test/iprc_chk.sv
/* Port checker for the interrupt priority controller.
   Sees only the controller ports; bound from the testbench top. */
`timescale 1ns/1ps
`default_nettype none
`include "iprc_regs.vh"
module iprc_chk #(
  parameter NSRC = 6,
  parameter NTRAP = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Events and CPU side
  input wire logic [NSRC-1:0] SRC_EVENT,
  input wire logic [NTRAP-1:0] TRAP_EVENT,
  input wire logic CPU_ACK,
  input wire logic CPU_RETURN,
  input wire logic CPU_TIMED_INTERRUPT_DISABLE,
  input wire logic IRQ,
  input wire logic [6:0] IRQ_VECTOR,
  input wire logic [3:0] IRQ_LEVEL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ******************************
  // Properties
  // ******************************
  property p_gfx_unimpl;
    RD && ADDR == `IPRC_OFS_GFX |=> RDATA[15:3] == 13'h0000;
  endproperty
  a_gfx_unimpl: assert property (p_gfx_unimpl)
    else $error("graphics unused bits not zero");
  property p_ack_drop;
    IRQ && CPU_ACK |=> !IRQ;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request stayed after acknowledge");
  property p_hold;
    IRQ && !CPU_ACK && !WR && !$past(WR) && !$past(WR, 2) && !$past(CPU_TIMED_INTERRUPT_DISABLE) |=> IRQ;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped without acknowledge");
  property p_no_lvl0;
    IRQ |-> IRQ_LEVEL != 4'h0;
  endproperty
  a_no_lvl0: assert property (p_no_lvl0)
    else $error("request at level zero");
  property p_vec_max;
    IRQ |-> IRQ_VECTOR <= 7'h76;
  endproperty
  a_vec_max: assert property (p_vec_max)
    else $error("vector above range");
  property p_trap_map;
    IRQ && IRQ_LEVEL[3] |-> IRQ_VECTOR == {4'h0, IRQ_LEVEL[2:0]};
  endproperty
  a_trap_map: assert property (p_trap_map)
    else $error("trap level and vector disagree");
  property p_user_map;
    IRQ && !IRQ_LEVEL[3] |-> IRQ_VECTOR >= 7'h08 && IRQ_VECTOR <= 7'h0D;
  endproperty
  a_user_map: assert property (p_user_map)
    else $error("user vector out of place");
  property p_trap_take;
    $rose(TRAP_EVENT[0]) |-> ##[1:4] IRQ && IRQ_LEVEL == 4'h8;
  endproperty
  a_trap_take: assert property (p_trap_take)
    else $error("trap not requested");
  c_ack: cover property (IRQ && CPU_ACK);
  c_trap: cover property (IRQ && IRQ_LEVEL[3]);
  c_stat: cover property (RD && ADDR == `IPRC_OFS_STATUS);
endmodule // iprc_chk
`default_nettype wire

// ===== test/iprc_cpu_model.sv
/* CPU core model: acknowledges a request after a chosen wait.
   Shares the controller clock. */
`timescale 1ns/1ps
`default_nettype none
module iprc_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request and control
  input wire logic irq,
  input wire logic en,
  input wire logic [3:0] dly,
  output logic ack
);
  logic [3:0] wait_q;
  // Count request cycles, then one acknowledge pulse
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_q <= 4'h0;
      ack <= 1'b0;
    end
    else
    begin
      ack <= irq && en && !ack && wait_q == dly;
      wait_q <= (irq && en && !ack && wait_q != dly) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // iprc_cpu_model
`default_nettype wire

// ===== test/interrupt_priority_controller_tb_top.sv
/* Testbench for the interrupt priority controller.
   Register tasks and events; a CPU model acknowledges requests. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_controller_tb_top;
  logic CLK = 0, ARST_N = 0, WR = 0, RD = 0, CPU_RETURN = 0, en = 0, CPU_TIMED_INTERRUPT_DISABLE = 0;
  logic [3:0] ADDR = 0, TRAP_EVENT = 0, dly = 0, IRQ_LEVEL;
  logic [15:0] WDATA = 0, rv, RDATA;
  logic [5:0] SRC_EVENT = 0;
  logic [6:0] IRQ_VECTOR;
  logic CPU_ACK, IRQ;
  int mismatches = 0, checks = 0, cyc = 0;
  // Clock and timeout
  always #2.5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  iprc_controller #(.TIMED_INTERRUPT_DISABLE_CYCLES(5)) u_iprc_controller (.CLK(CLK), .ARST_N(ARST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SRC_EVENT(SRC_EVENT),
    .TRAP_EVENT(TRAP_EVENT), .CPU_ACK(CPU_ACK), .CPU_RETURN(CPU_RETURN), .CPU_TIMED_INTERRUPT_DISABLE(CPU_TIMED_INTERRUPT_DISABLE),
    .IRQ(IRQ), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL));
  iprc_cpu_model u_iprc_cpu_model (.clk(CLK), .arst_n(ARST_N), .irq(IRQ), .en(en),
    .dly(dly), .ack(CPU_ACK));
  // ******************************
  // Tasks
  // ******************************
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  task ev(input logic [5:0] s, input logic [3:0] t);
    @(posedge CLK);
    SRC_EVENT <= s;
    TRAP_EVENT <= t;
    @(posedge CLK);
    SRC_EVENT <= 6'h00;
    TRAP_EVENT <= 4'h0;
    wt(4);
  endtask
  task ret;
    @(posedge CLK);
    CPU_RETURN <= 1'b1;
    @(posedge CLK);
    CPU_RETURN <= 1'b0;
    wt(4);
  endtask
  task tally_and_finish;
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(4'h0); chk("spi3_uart4", rv, 16'h0444);
    rd(4'h1); chk("cap9_cmp9", rv, 16'h0044);
    rd(4'h2); chk("gfx", rv, 16'h0004);
    rd(4'h3); chk("status", rv, 16'h0000);
    wr(4'h0, 16'hFFFF); wr(4'h1, 16'hFFFF); wr(4'h2, 16'hFFFF);
    rd(4'h0); chk("spi3_uart4", rv, 16'h0777);
    rd(4'h1); chk("cap9_cmp9", rv, 16'h0077);
    rd(4'h2); chk("gfx", rv, 16'h0007);
    rd(4'h8); chk("unmapped", rv, 16'h0000);
    wr(4'h0, 16'h0055); wr(4'h1, 16'h0003); wr(4'h2, 16'h0000);
    wr(4'h4, 16'hFFFF);
    wr(4'h5, 16'h003F);
    ev(6'h01, 4'h0); chk("irq", {15'h0, IRQ}, 16'h0000);
    ev(6'h16, 4'h0); chk("vec", {9'h0, IRQ_VECTOR}, 16'h0009);
    chk("lvl", {12'h0, IRQ_LEVEL}, 16'h0005);
    wr(4'h6, 16'h00EE); wt(3); chk("irq", {15'h0, IRQ}, 16'h0000);
    wr(4'h3, 16'h2000); rd(4'h3); chk("pend", {15'h0, rv[15]}, 16'h0001);
    chk("vec_now", {9'h0, rv[6:0]}, 16'h0009);
    ev(6'h00, 4'h1); chk("trap", {11'h0, IRQ, IRQ_LEVEL}, 16'h0018);
    @(posedge CLK) en <= 1'b1;
    wt(4); chk("trap_again", {15'h0, IRQ}, 16'h0001);
    wr(4'h7, 16'h000F);
    ret; chk("irq", {15'h0, IRQ}, 16'h0000);
    wr(4'h3, 16'h0000);
    @(posedge CLK) dly <= 4'h6;
    wr(4'h6, 16'h0000); wt(14); chk("irq", {15'h0, IRQ}, 16'h0000);
    rd(4'h3); chk("vec_ack", {9'h0, rv[6:0]}, 16'h0009);
    @(posedge CLK) en <= 1'b0;
    ret; chk("again", {8'h0, IRQ, IRQ_VECTOR}, 16'h0089);
    @(posedge CLK) CPU_TIMED_INTERRUPT_DISABLE <= 1'b1;
    @(posedge CLK) CPU_TIMED_INTERRUPT_DISABLE <= 1'b0;
    wt(1); chk("timed_interrupt_disable", {15'h0, IRQ}, 16'h0000);
    wt(8); chk("timed_interrupt_disable_end", {15'h0, IRQ}, 16'h0001);
    tally_and_finish;
  end
endmodule // interrupt_priority_controller_tb_top
bind iprc_controller iprc_chk #(.NSRC(NSRC), .NTRAP(NTRAP)) u_iprc_chk (.CLK(CLK),
  .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SRC_EVENT(SRC_EVENT), .TRAP_EVENT(TRAP_EVENT), .CPU_ACK(CPU_ACK), .CPU_RETURN(CPU_RETURN),
  .CPU_TIMED_INTERRUPT_DISABLE(CPU_TIMED_INTERRUPT_DISABLE), .IRQ(IRQ), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL));
`default_nettype wire
